/* hw/lmb_pkg.sv */
// constants and types shared by the display and memory bus port
package lmb_pkg;
	localparam int CLK_MHZ = 200;
	localparam int SETUP_NS = 10;
	localparam int STROBE_NS = 70;
	localparam int HOLD_NS = 10;
	localparam int SETUP_CYC = (SETUP_NS * CLK_MHZ + 999) / 1000;
	localparam int STROBE_CYC = (STROBE_NS * CLK_MHZ + 999) / 1000;
	localparam int HOLD_CYC = (HOLD_NS * CLK_MHZ + 999) / 1000;
	localparam int CNT_W = 8;
	localparam int ADDR_W = 22;
	localparam int DATA_W = 16;
	localparam int DISP_W = 8;
	localparam int CMD_BIT = 2;
	localparam int FLASH_WORD_W = 22;
	localparam int RAM_WORD_W = 20;
	localparam int FIFO_DEPTH = 32;
	localparam logic [1:0] TGT_DISPLAY = 2'h0;
	localparam logic [1:0] TGT_FLASH = 2'h1;
	localparam logic [1:0] TGT_RAM = 2'h2;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_SETUP = 2'b01,
		ST_STROBE = 2'b10,
		ST_HOLD = 2'b11
	} lmb_state_t;

	typedef struct packed {
		logic write;
		logic cmd;
		logic [1:0] target;
		logic [1:0] byte_en;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
	} lmb_req_t;

	localparam int REQ_W = $bits(lmb_req_t);
endpackage

/* hw/lmb_stream_if.sv */
// valid/ready stream carrier between the port's own modules
interface lmb_stream_if #(
	parameter int WIDTH = 8
);
	logic valid;
	logic ready;
	logic [WIDTH-1:0] data;
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface

/* hw/lmb_fifo.sv */
// request fifo in front of the bus engine
module lmb_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 32
) (
	input wire logic clock,
	input wire logic rst,
	lmb_stream_if.snk fill,
	lmb_stream_if.src drain
);
	localparam int AW = $clog2(DEPTH);
	localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

	typedef struct packed {
		logic [AW-1:0] wr_ptr;
		logic [AW-1:0] rd_ptr;
		logic [AW:0] count;
	} lmb_fifo_st_t;

	lmb_fifo_st_t s_r, s_nxt;
	logic [WIDTH-1:0] mem [DEPTH];
	logic push, pop;

	function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
		bump = (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
	endfunction

	assign fill.ready = (s_r.count != FULL_CNT);
	assign drain.valid = (s_r.count != '0);
	assign drain.data = mem[s_r.rd_ptr];
	assign push = fill.valid & fill.ready;
	assign pop = drain.valid & drain.ready;

	always_comb begin
		s_nxt = s_r;
		if (push) begin
			s_nxt.wr_ptr = bump(s_r.wr_ptr);
		end
		if (pop) begin
			s_nxt.rd_ptr = bump(s_r.rd_ptr);
		end
		case ({push, pop})
			2'b10: s_nxt.count = s_r.count + 1'b1;
			2'b01: s_nxt.count = s_r.count - 1'b1;
			default: s_nxt.count = s_r.count;
		endcase
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	// storage has no reset; only the pointers and the count need a defined start
	always_ff @(posedge clock) begin
		if (push) begin
			mem[s_r.wr_ptr] <= fill.data;
		end
	end
endmodule // lmb_fifo

/* hw/lmb_port.sv */
// external bus port driving the display and the flash/pseudo-static ram package

module lmb_port #(
	parameter int DEPTH = lmb_pkg::FIFO_DEPTH
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic req_valid,
	output logic req_ready,
	input wire logic req_write,
	input wire logic req_cmd,
	input wire logic [1:0] req_target,
	input wire logic [1:0] req_byte_en,
	input wire logic [lmb_pkg::ADDR_W-1:0] req_addr,
	input wire logic [lmb_pkg::DATA_W-1:0] req_wdata,
	output logic rd_valid,
	output logic [lmb_pkg::DATA_W-1:0] rd_data,
	output logic req_error,
	input wire logic glow_request,
	input wire logic sleep_mode,
	output logic panel_glow_enable,
	output logic display_select_n,
	output logic flash_select_n,
	output logic ram_select_n,
	output logic write_strobe_n,
	output logic output_strobe_n,
	output logic high_byte_enable,
	output logic [lmb_pkg::ADDR_W-1:0] bus_addr,
	output logic [lmb_pkg::DATA_W-1:0] bus_data_out,
	output logic bus_data_oe,
	input wire logic [lmb_pkg::DATA_W-1:0] bus_data_in
);
	localparam logic [lmb_pkg::CNT_W-1:0] SETUP_LAST = lmb_pkg::CNT_W'(lmb_pkg::SETUP_CYC - 1);
	localparam logic [lmb_pkg::CNT_W-1:0] STROBE_LAST = lmb_pkg::CNT_W'(lmb_pkg::STROBE_CYC - 1);
	localparam logic [lmb_pkg::CNT_W-1:0] HOLD_LAST = lmb_pkg::CNT_W'(lmb_pkg::HOLD_CYC - 1);

	typedef struct packed {
		lmb_pkg::lmb_state_t state;
		logic [lmb_pkg::CNT_W-1:0] cnt;
		logic write;
		logic rd_valid;
		logic [lmb_pkg::DATA_W-1:0] rd_data;
		logic error;
		logic glow;
		logic disp_sel_n;
		logic flash_sel_n;
		logic ram_sel_n;
		logic wr_n;
		logic oe_n;
		logic hi_en;
		logic [lmb_pkg::ADDR_W-1:0] addr;
		logic [lmb_pkg::DATA_W-1:0] dout;
		logic doe;
	} lmb_port_st_t;

	lmb_port_st_t s_r, s_nxt;
	lmb_pkg::lmb_req_t in_req, head;

	lmb_stream_if #(.WIDTH(lmb_pkg::REQ_W)) fill_if ();
	lmb_stream_if #(.WIDTH(lmb_pkg::REQ_W)) drain_if ();

	assign in_req.write = req_write;
	assign in_req.cmd = req_cmd;
	assign in_req.target = req_target;
	assign in_req.byte_en = req_byte_en;
	assign in_req.addr = req_addr;
	assign in_req.data = req_wdata;
	assign fill_if.valid = req_valid;
	assign fill_if.data = in_req;
	assign req_ready = fill_if.ready;

	lmb_fifo #(
		.WIDTH(lmb_pkg::REQ_W),
		.DEPTH(DEPTH)
	) u_fifo (
		.clock(clock),
		.rst(rst),
		.fill(fill_if),
		.drain(drain_if)
	);

	assign head = drain_if.data;
	// the engine pops only when idle, so a stalled bus backs the fifo up to the source
	assign drain_if.ready = (s_r.state == lmb_pkg::ST_IDLE);

	// byte lanes of a ram access: bit 0 of the address carries the low lane
	function automatic logic [lmb_pkg::ADDR_W-1:0] ram_addr(input lmb_pkg::lmb_req_t r);
		// bit 21 stays low: the ram spans only twenty word address bits
		ram_addr = lmb_pkg::ADDR_W'({r.addr[lmb_pkg::RAM_WORD_W:1], r.byte_en[0]});
	endfunction

	always_comb begin
		s_nxt = s_r;
		s_nxt.rd_valid = 1'b0;
		s_nxt.error = 1'b0;
		s_nxt.glow = glow_request & ~sleep_mode;
		case (s_r.state)
			lmb_pkg::ST_IDLE: begin
				if (drain_if.valid) begin
					s_nxt.write = head.write;
					s_nxt.cnt = SETUP_LAST;
					s_nxt.state = lmb_pkg::ST_SETUP;
					s_nxt.doe = head.write;
					s_nxt.hi_en = 1'b1;
					case (head.target)
						lmb_pkg::TGT_DISPLAY: begin
							if (head.write) begin
								s_nxt.disp_sel_n = 1'b0;
								s_nxt.addr = '0;
								s_nxt.addr[lmb_pkg::CMD_BIT] = head.cmd;
								s_nxt.dout = {{(lmb_pkg::DATA_W - lmb_pkg::DISP_W){1'b0}},
									head.data[lmb_pkg::DISP_W-1:0]};
							end else begin
								// display has no read path, the request is dropped
								s_nxt.error = 1'b1;
								s_nxt.state = lmb_pkg::ST_IDLE;
								s_nxt.doe = 1'b0;
							end
						end
						lmb_pkg::TGT_FLASH: begin
							s_nxt.flash_sel_n = 1'b0;
							s_nxt.addr = head.addr[lmb_pkg::FLASH_WORD_W-1:0];
							s_nxt.dout = head.data;
						end
						lmb_pkg::TGT_RAM: begin
							s_nxt.ram_sel_n = 1'b0;
							s_nxt.addr = ram_addr(head);
							s_nxt.hi_en = head.byte_en[1];
							s_nxt.dout = head.data;
						end
						default: begin
							s_nxt.error = 1'b1;
							s_nxt.state = lmb_pkg::ST_IDLE;
							s_nxt.doe = 1'b0;
						end
					endcase
				end
			end
			lmb_pkg::ST_SETUP: begin
				// address and select settle before the strobe falls
				if (s_r.cnt == '0) begin
					s_nxt.wr_n = ~s_r.write;
					s_nxt.oe_n = s_r.write;
					s_nxt.cnt = STROBE_LAST;
					s_nxt.state = lmb_pkg::ST_STROBE;
				end else begin
					s_nxt.cnt = s_r.cnt - 1'b1;
				end
			end
			lmb_pkg::ST_STROBE: begin
				if (s_r.cnt == '0) begin
					s_nxt.wr_n = 1'b1;
					s_nxt.oe_n = 1'b1;
					if (!s_r.write) begin
						// sampled while output strobe is still low
						s_nxt.rd_valid = 1'b1;
						s_nxt.rd_data = bus_data_in;
					end
					s_nxt.cnt = HOLD_LAST;
					s_nxt.state = lmb_pkg::ST_HOLD;
				end else begin
					s_nxt.cnt = s_r.cnt - 1'b1;
				end
			end
			lmb_pkg::ST_HOLD: begin
				// everything held a while after the strobe rises
				if (s_r.cnt == '0) begin
					s_nxt.disp_sel_n = 1'b1;
					s_nxt.flash_sel_n = 1'b1;
					s_nxt.ram_sel_n = 1'b1;
					s_nxt.doe = 1'b0;
					s_nxt.state = lmb_pkg::ST_IDLE;
				end else begin
					s_nxt.cnt = s_r.cnt - 1'b1;
				end
			end
			default: begin
				s_nxt.state = lmb_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			s_r <= '{state: lmb_pkg::ST_IDLE, cnt: '0, write: 1'b0, rd_valid: 1'b0, rd_data: '0,
				error: 1'b0, glow: 1'b0, disp_sel_n: 1'b1, flash_sel_n: 1'b1, ram_sel_n: 1'b1,
				wr_n: 1'b1, oe_n: 1'b1, hi_en: 1'b0, addr: '0, dout: '0, doe: 1'b0};
		end else begin
			s_r <= s_nxt;
		end
	end

	assign rd_valid = s_r.rd_valid;
	assign rd_data = s_r.rd_data;
	assign req_error = s_r.error;
	assign panel_glow_enable = s_r.glow;
	assign display_select_n = s_r.disp_sel_n;
	assign flash_select_n = s_r.flash_sel_n;
	assign ram_select_n = s_r.ram_sel_n;
	assign write_strobe_n = s_r.wr_n;
	assign output_strobe_n = s_r.oe_n;
	assign high_byte_enable = s_r.hi_en;
	assign bus_addr = s_r.addr;
	assign bus_data_out = s_r.dout;
	assign bus_data_oe = s_r.doe;
endmodule // lmb_port

/* sim/lmb_props.sv */
// assertions on the pins of the display and memory bus port
module lmb_props (
	input wire logic clock,
	input wire logic rst,
	input wire logic glow_request,
	input wire logic sleep_mode,
	input wire logic panel_glow_enable,
	input wire logic display_select_n,
	input wire logic flash_select_n,
	input wire logic ram_select_n,
	input wire logic write_strobe_n,
	input wire logic output_strobe_n,
	input wire logic bus_data_oe,
	input wire logic rd_valid,
	input wire logic [lmb_pkg::ADDR_W-1:0] bus_addr,
	input wire logic [lmb_pkg::DATA_W-1:0] bus_data_out
);
	wire any_sel = !(display_select_n && flash_select_n && ram_select_n);
	wire strobe = !(write_strobe_n && output_strobe_n);
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	AST_GLOW_SLEEP: assert property (sleep_mode |=> !panel_glow_enable) else $error("glow on in sleep");
	AST_GLOW_ON: assert property (glow_request && !sleep_mode |=> panel_glow_enable) else $error("glow off");
	AST_ONE_SEL: assert property ($onehot0({display_select_n, flash_select_n, ram_select_n} ^ 3'h7))
		else $error("two selects low");
	AST_STROBE_SEL: assert property (strobe |-> any_sel && $past(any_sel, 2)) else $error("strobe without select");
	AST_NO_DISP_RD: assert property (!display_select_n |-> output_strobe_n) else $error("display read");
	AST_WR_DRIVE: assert property (!write_strobe_n |-> bus_data_oe) else $error("write data not driven");
	AST_RD_FLOAT: assert property (!output_strobe_n |-> !bus_data_oe) else $error("driving during read");
	AST_WR_LEN: assert property ($fell(write_strobe_n) |-> ##13 !write_strobe_n ##1 write_strobe_n)
		else $error("write strobe length");
	AST_RD_DONE: assert property ($fell(output_strobe_n) |-> ##14 output_strobe_n && rd_valid)
		else $error("read end");
	AST_HOLD: assert property (strobe ##1 strobe |-> $stable(bus_addr) && $stable(bus_data_out))
		else $error("bus moved under strobe");
	cover property ($fell(write_strobe_n) && !display_select_n);
	cover property ($fell(output_strobe_n) && !flash_select_n);
	cover property ($fell(write_strobe_n) && !ram_select_n);
endmodule // lmb_props

bind lmb_port lmb_props chk_u (.clock, .rst, .glow_request, .sleep_mode, .panel_glow_enable, .display_select_n,
	.flash_select_n, .ram_select_n, .write_strobe_n, .output_strobe_n, .bus_data_oe, .rd_valid, .bus_addr,
	.bus_data_out);

/* sim/lmb_mem_model.sv */
// behavioural display and flash/pseudo-static ram beyond the bus pins
module lmb_mem_model #(
	parameter int LAT_NS = 0
) (
	input wire logic rst,
	input wire logic display_select_n,
	input wire logic flash_select_n,
	input wire logic ram_select_n,
	input wire logic write_strobe_n,
	input wire logic output_strobe_n,
	input wire logic high_byte_enable,
	input wire logic [lmb_pkg::ADDR_W-1:0] bus_addr,
	input wire logic [lmb_pkg::DATA_W-1:0] bus_data_out,
	output logic [lmb_pkg::DATA_W-1:0] bus_data_in
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] flash_mem [256];
	logic [15:0] ram_mem [256];
	logic [15:0] last_q;
	logic [7:0] disp_cmd;
	logic [7:0] disp_data;
	int wr_cnt;
	wire rd_on = !output_strobe_n && !(flash_select_n && ram_select_n);
	// no pull on the data lines, so released lines show the inverse of the last read
	assign #(LAT_NS) bus_data_in = rd_on ? (flash_select_n ? ram_mem[bus_addr[8:1]] : flash_mem[bus_addr[7:0]]) : ~last_q;
	always @(posedge output_strobe_n or posedge rst) last_q <= rst ? 16'h0 : bus_data_in;
	always @(posedge write_strobe_n or posedge rst) begin
		if (rst) begin
			disp_cmd <= 8'h00;
			disp_data <= 8'h00;
			wr_cnt <= 0;
		end else begin
			wr_cnt <= wr_cnt + 1;
			if (!display_select_n && bus_addr[2]) disp_cmd <= bus_data_out[7:0];
			if (!display_select_n && !bus_addr[2]) disp_data <= bus_data_out[7:0];
			if (!flash_select_n) flash_mem[bus_addr[7:0]] <= bus_data_out;
			if (!ram_select_n && bus_addr[0]) ram_mem[bus_addr[8:1]][7:0] <= bus_data_out[7:0];
			if (!ram_select_n && high_byte_enable) ram_mem[bus_addr[8:1]][15:8] <= bus_data_out[15:8];
		end
	end
endmodule // lmb_mem_model

/* sim/tb_top.sv */
// self-checking bench for the display and memory bus port
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clock, rst, req_valid, req_write, req_cmd, glow_request, sleep_mode, saw_full;
	logic req_ready, rd_valid, req_error, panel_glow_enable, display_select_n, flash_select_n, ram_select_n;
	logic write_strobe_n, output_strobe_n, high_byte_enable, bus_data_oe;
	logic [1:0] req_target, req_byte_en;
	logic [21:0] req_addr, bus_addr;
	logic [15:0] req_wdata, bus_data_in, bus_data_out, rd_data;
	int fail_count, comparisons, nw;
	lmb_port dut_u (.clock, .rst, .req_valid, .req_ready, .req_write, .req_cmd, .req_target, .req_byte_en,
		.req_addr, .req_wdata, .rd_valid, .rd_data, .req_error, .glow_request, .sleep_mode, .panel_glow_enable,
		.display_select_n, .flash_select_n, .ram_select_n, .write_strobe_n, .output_strobe_n, .high_byte_enable,
		.bus_addr, .bus_data_out, .bus_data_oe, .bus_data_in);
	lmb_mem_model #(.LAT_NS(40)) mem_u (.rst, .display_select_n, .flash_select_n, .ram_select_n,
		.write_strobe_n, .output_strobe_n, .high_byte_enable, .bus_addr, .bus_data_out, .bus_data_in);
	initial begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			fail_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic send(input logic w, c, input logic [1:0] t, b, input logic [21:0] a, input logic [15:0] d);
		@(posedge clock);
		req_valid <= 1'b1;
		req_write <= w;
		req_cmd <= c;
		req_target <= t;
		req_byte_en <= b;
		req_addr <= a;
		req_wdata <= d;
		if (w && t != 2'h3) nw++;
		do begin
			@(negedge clock);
			if (!req_ready) saw_full = 1'b1;
		end while (!req_ready);
	endtask
	task automatic wait_ev(input bit err, input logic [15:0] exp);
		int n;
		n = 0;
		@(posedge clock);
		req_valid <= 1'b0;
		do begin
			@(negedge clock);
			n++;
		end while (!(err ? req_error === 1'b1 : rd_valid === 1'b1) && n < 300);
		chk(err ? {15'h0, req_error} : rd_data, err ? 16'h1 : exp);
	endtask
	task automatic wait_wr();
		int n;
		n = 0;
		@(posedge clock);
		req_valid <= 1'b0;
		do begin
			@(negedge clock);
			n++;
		end while (mem_u.wr_cnt != nw && n < 2000);
		chk(16'(mem_u.wr_cnt), 16'(nw));
	endtask
	task automatic t_glow();
		@(posedge clock);
		glow_request <= 1'b1;
		repeat (2) @(posedge clock);
		sleep_mode <= 1'b1;
		#1 chk(panel_glow_enable, 16'h1);
		@(posedge clock);
		#1 chk(panel_glow_enable, 16'h0);
		@(posedge clock);
		sleep_mode <= 1'b0;
		@(posedge clock);
		#1 chk(panel_glow_enable, 16'h1);
		$display("test glow done");
	endtask
	task automatic t_disp();
		send(1'b1, 1'b1, 2'h0, 2'h3, 22'h0, 16'hffa5);
		send(1'b1, 1'b0, 2'h0, 2'h3, 22'h0, 16'hff3c);
		send(1'b0, 1'b0, 2'h0, 2'h3, 22'h0, 16'h0);
		wait_ev(1'b1, 16'h0);
		wait_wr();
		chk(mem_u.disp_cmd, 16'ha5);
		chk(mem_u.disp_data, 16'h3c);
		$display("test display done");
	endtask
	task automatic t_mem();
		send(1'b1, 1'b0, 2'h1, 2'h3, 22'h8, 16'h5a5a);
		send(1'b1, 1'b0, 2'h2, 2'h3, 22'h8, 16'h1234);
		send(1'b1, 1'b0, 2'h2, 2'h1, 22'h8, 16'habcd);
		send(1'b0, 1'b0, 2'h1, 2'h3, 22'h8, 16'h0);
		wait_ev(1'b0, 16'h5a5a);
		send(1'b0, 1'b0, 2'h2, 2'h3, 22'h8, 16'h0);
		wait_ev(1'b0, 16'h12cd);
		send(1'b1, 1'b0, 2'h3, 2'h3, 22'h8, 16'h0);
		wait_ev(1'b1, 16'h0);
		wait_wr();
		$display("test memory done");
	endtask
	task automatic t_fill();
		// offered every cycle while the engine takes about twenty per entry, so the fifo must refuse
		saw_full = 1'b0;
		for (int i = 0; i < 40; i++) send(1'b1, 1'b0, 2'h0, 2'h3, 22'h0, 16'(i));
		wait_wr();
		chk(saw_full, 16'h1);
		chk(mem_u.disp_data, 16'h27);
		chk(req_ready, 16'h1);
		$display("test fill done");
	endtask
	task automatic t_reset();
		// a second reset mid-run: the display restarts and the port must come back idle
		@(posedge clock);
		rst <= 1'b1;
		glow_request <= 1'b0;
		nw = 0;
		repeat (2) @(posedge clock);
		#1 chk(mem_u.disp_cmd, 16'h0);
		chk({display_select_n, flash_select_n, ram_select_n, write_strobe_n, output_strobe_n, bus_data_oe,
			panel_glow_enable, req_ready}, 16'hf9);
		@(posedge clock);
		rst <= 1'b0;
		send(1'b1, 1'b1, 2'h0, 2'h3, 22'h0, 16'h0069);
		wait_wr();
		chk(mem_u.disp_cmd, 16'h69);
		$display("test reset done");
	endtask
	task automatic final_report();
		$display("comparisons %0d fail_count %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	initial begin
		#100000;
		fail_count++;
		final_report();
	end
	initial begin
		{rst, req_valid, req_write, req_cmd, glow_request, sleep_mode} = 6'h20;
		{req_target, req_byte_en, req_addr, req_wdata} = '0;
		fail_count = 0;
		comparisons = 0;
		nw = 0;
		repeat (6) @(posedge clock);
		rst <= 1'b0;
		t_glow();
		t_disp();
		t_mem();
		t_fill();
		t_reset();
		final_report();
	end
endmodule // tb_top
